/* fp_int_convert_compare_unit.sv */
// Floating-point to integer conversion and compare unit behind an APB slave.
// Assumes software loads operands, then writes an instruction word and polls or waits for irq.
//
// Contract
// RULE1: A compare with any NaN operand is unordered and sets the flags to 0011.
// RULE2: The raise-on-any-NaN compare flags invalid for quiet and signalling NaNs alike.
// RULE3: The directed conversion rounds ties-away, ties-even, up or down for select 00 to 11.
// RULE4: The directed conversion gives an unsigned result at signedness 0, signed at 1.
// RULE5: The core never issues a directed conversion inside a conditional block.
// RULE6: Precision bit 1 selects double values, and is undefined where only single exists.
// RULE7: Opcode 101 converts to signed, 100 to unsigned, 000 converts integer to float.
// RULE8: Float to integer rounds to zero at bit 1, and by the status rounding mode at 0.
// RULE9: Integer to float rounds by the status mode, source signed at bit 1, unsigned at 0.
// RULE10: Opcodes other than 000 and 10x are not executed as this conversion.
// RULE11: Conversions report invalid, input-denormal and inexact exceptions.
// RULE12: Compares report only invalid and input-denormal, never inexact.
// RULE13: Destination and source register indexes are joined in the order set by precision.
// RULE14: The integer side of every conversion is a 32-bit word of a single register.
// RULE15: With the unit disabled an instruction raises undefined instead of executing.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ns
`include "fp_cvt_map.svh"
module fp_int_convert_compare_unit
  import fp_cvt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------------
  function automatic unpacked_t unpackFp(logic [63:0] v, logic dp, logic fz);
    unpacked_t u;
    logic [10:0] e;
    logic [51:0] f;
    logic [12:0] bias;
    logic ones;
    u = '0;
    e = dp ? v[62:52] : {3'h0, v[30:23]};
    f = dp ? v[51:0] : {v[22:0], 29'h0};
    bias = dp ? `DP_BIAS : `SP_BIAS;
    ones = e == (dp ? `DP_EXP_ONES : `SP_EXP_ONES);
    u.sign = dp ? v[63] : v[31];
    u.isNan = ones & (f != 52'h0);
    u.isSnan = u.isNan & ~f[51];
    u.isInf = ones & (f == 52'h0);
    u.isDen = (e == 11'h0) & (f != 52'h0);
    // Flushing a denormal input makes it an exact zero of the same sign.
    u.isZero = (e == 11'h0) & ((f == 52'h0) | fz);
    u.exp = (e == 11'h0) ? 13'h0001 - bias : {2'h0, e} - bias;
    u.mant = u.isZero ? 53'h0 : {e != 11'h0, f};
    return u;
  endfunction

  function automatic logic roundUp(round_t r, logic sign, logic lsb, logic g, logic s);
    case (r)
      RND_NEAR_EVEN: return g & (s | lsb);
      RND_NEAR_AWAY: return g;
      RND_PLUS: return ~sign & (g | s);
      RND_MINUS: return sign & (g | s);
      default: return 1'b0;
    endcase
  endfunction

  function automatic round_t statusRound(logic [1:0] m);
    case (m)
      `RMODE_NEAREST: return RND_NEAR_EVEN;
      `RMODE_PLUS: return RND_PLUS;
      `RMODE_MINUS: return RND_MINUS;
      default: return RND_ZERO;
    endcase
  endfunction

  function automatic round_t directedRound(logic [1:0] sel);
    case (sel)
      `RSEL_AWAY: return RND_NEAR_AWAY; // RULE3
      `RSEL_EVEN: return RND_NEAR_EVEN; // RULE3
      `RSEL_PLUS: return RND_PLUS; // RULE3
      default: return RND_MINUS; // RULE3
    endcase
  endfunction

  function automatic int_result_t floatToInt(unpacked_t u, logic uns, round_t r);
    int_result_t res;
    logic [12:0] shift;
    logic [127:0] ext;
    logic [64:0] mag;
    logic g;
    logic s;
    res = '0;
    ext = '0;
    g = 1'b0;
    s = 1'b0;
    shift = `FTOI_POINT - u.exp;
    if ($signed(u.exp) > $signed(`FTOI_MAX_EXP) || u.isInf) begin
      mag = `FTOI_HUGE;
    end else if ($signed(u.exp) < $signed(`FTOI_MIN_EXP)) begin
      mag = 65'h0;
      s = |u.mant;
    end else begin
      ext = {11'h0, u.mant, 64'h0} >> shift[6:0];
      g = ext[63];
      s = |ext[62:0];
      mag = {1'b0, ext[127:64]} + {64'h0, roundUp(r, u.sign, ext[64], g, s)};
    end
    res.exc.inexact = g | s; // RULE11
    if (u.isNan) begin
      res.exc.invalid = 1'b1; // RULE11
    end else if (uns) begin
      if (u.sign && mag != 65'h0) begin
        res.exc.invalid = 1'b1;
      end else if (mag > {33'h0, `SAT_UNSIGNED}) begin
        res.exc.invalid = 1'b1;
        res.value = `SAT_UNSIGNED;
      end else begin
        res.value = mag[31:0];
      end
    end else if (!u.sign && mag > {33'h0, `SAT_POS}) begin
      res.exc.invalid = 1'b1;
      res.value = `SAT_POS;
    end else if (u.sign && mag > {33'h0, `SAT_NEG}) begin
      res.exc.invalid = 1'b1;
      res.value = `SAT_NEG;
    end else begin
      res.value = u.sign ? ~mag[31:0] + 32'h1 : mag[31:0];
    end
    // An out-of-range result is reported as invalid only, never also inexact.
    if (res.exc.invalid) begin
      res.exc.inexact = 1'b0;
    end
    return res;
  endfunction

  function automatic logic [4:0] leadOne(logic [31:0] v);
    logic [4:0] p;
    p = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    return p;
  endfunction

  function automatic float_result_t intToFloat(logic [31:0] src, logic uns, round_t r,
                                               logic dp);
    float_result_t res;
    logic sign;
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0] p;
    logic [23:0] frac;
    logic [7:0] e8;
    logic [10:0] e11;
    res = '0;
    sign = ~uns & src[31]; // RULE9
    mag = sign ? ~src + 32'h1 : src;
    p = leadOne(mag);
    norm = mag << (5'h1f - p);
    frac = {1'b0, norm[30:8]} + {23'h0, roundUp(r, sign, norm[8], norm[7], |norm[6:0])};
    e8 = 8'(`SP_BIAS) + {3'h0, p} + {7'h0, frac[23]};
    e11 = 11'(`DP_BIAS) + {6'h0, p};
    if (mag == 32'h0) begin
      res.value = 64'h0;
    end else if (dp) begin
      // Every 32-bit integer fits a double mantissa, so this path is always exact.
      res.value = {sign, e11, norm[30:0], 21'h0};
    end else begin
      res.value = {32'h0, sign, e8, frac[22:0]};
      res.exc.inexact = |norm[7:0]; // RULE11
    end
    return res;
  endfunction

  function automatic cmp_result_t compareFp(unpacked_t a, unpacked_t b, logic anyNan);
    cmp_result_t res;
    logic [65:0] keyA;
    logic [65:0] keyB;
    logic less;
    res = '0;
    keyA = {~a.exp[12], a.exp[11:0], a.mant};
    keyB = {~b.exp[12], b.exp[11:0], b.mant};
    less = (a.sign != b.sign) ? a.sign : (a.sign ? keyA > keyB : keyA < keyB);
    if (a.isNan || b.isNan) begin
      res.nzcv = `NZCV_UNORDERED; // RULE1
      res.exc.invalid = a.isSnan | b.isSnan | anyNan; // RULE2
    end else if ((a.isZero && b.isZero) || (a.sign == b.sign && keyA == keyB)) begin
      res.nzcv = `NZCV_EQUAL;
    end else begin
      res.nzcv = less ? `NZCV_LESS : `NZCV_GREATER;
    end
    return res;
  endfunction

  function automatic logic [4:0] joinIndex(logic [3:0] field, logic extra, logic dpOrder);
    return dpOrder ? {extra, field} : {field, extra};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  state_t state;
  logic [2:0] loadStep;
  logic [1:0] ctrl;
  instr_t instr;
  logic [3:0][31:0] operand;
  logic [63:0] result;
  logic [3:0] nzcv;
  logic flushZero;
  logic [1:0] roundMode;
  fp_exc_t cumExc;
  logic [4:0] destIdx;
  logic [4:0] srcIdx;
  logic [`IRQ_WIDTH-1:0] irqStatus;
  logic [`IRQ_WIDTH-1:0] irqEnable;
  logic [31:0] memBusData;
  logic [31:0] memExecData;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire accessCycle = psel & penable & ~pready;
  wire writeDone = psel & penable & pready & pwrite;
  wire hitCtrl = paddr == `ADDR_CTRL;
  wire hitStatus = paddr == `ADDR_STATUS;
  wire hitInstr = paddr == `ADDR_INSTR;
  wire hitIndex = paddr == `ADDR_INDEX;
  wire hitOperand = paddr[7:4] == `ADDR_OPERAND_PAGE;
  wire hitResLo = paddr == `ADDR_RESULT_LO;
  wire hitResHi = paddr == `ADDR_RESULT_HI;
  wire hitIrqStatus = paddr == `ADDR_IRQ_STATUS;
  wire hitIrqClear = paddr == `ADDR_IRQ_CLEAR;
  wire hitIrqEnable = paddr == `ADDR_IRQ_ENABLE;
  wire mapped = hitCtrl | hitStatus | hitInstr | hitIndex | hitOperand | hitResLo | hitResHi |
                hitIrqStatus | hitIrqClear | hitIrqEnable;
  wire statusWrite = writeDone & hitStatus;
  wire busy = state != ST_IDLE;

  logic [31:0] statusRead;
  logic [31:0] indexRead;
  logic [31:0] readMux;
  assign statusRead = (32'(nzcv) << `STATUS_NZCV_LSB) | (32'(flushZero) << `STATUS_FZ) |
                      (32'(roundMode) << `STATUS_RMODE_LSB) | (32'(cumExc.denormal) << `STATUS_IDC) |
                      (32'(cumExc.inexact) << `STATUS_IXC) | (32'(cumExc.invalid) << `STATUS_IOC);
  assign indexRead = 32'(destIdx) | (32'(srcIdx) << `INDEX_SRC_LSB) | (32'(busy) << `INDEX_BUSY);
  assign readMux = hitCtrl ? 32'(ctrl) :
                   hitStatus ? statusRead :
                   hitInstr ? 32'(instr) :
                   hitIndex ? indexRead :
                   hitOperand ? memBusData :
                   hitResLo ? result[31:0] :
                   hitResHi ? result[63:32] :
                   hitIrqStatus ? 32'(irqStatus) :
                   hitIrqEnable ? 32'(irqEnable) : 32'h0;

  // ----------------------------------------------------------------------
  // Operand memory
  // ----------------------------------------------------------------------
  operand_store operandStore (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(writeDone & hitOperand),
    .wrAddr(paddr[3:2]),
    .wrData(pwdata),
    .busAddr(paddr[3:2]),
    .busData(memBusData),
    .execAddr(loadStep[1:0]),
    .execData(memExecData)
  );

  // ----------------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------------
  wire dpOp = instr.precisionSelect; // RULE6
  wire isDirected = instr.opClass == OP_DIRECTED;
  wire isIntCvt = instr.opClass == OP_INTCVT;
  wire isCompare = instr.opClass == OP_COMPARE;
  wire toFloat = isIntCvt & (instr.convOpcode == `OPC_TO_FLOAT); // RULE7
  wire toIntOpc = isIntCvt & (instr.convOpcode[2:1] == `OPC_TO_INT_HI); // RULE7
  wire ftoiActive = isDirected | toIntOpc;
  // Unmatched opcodes belong to other encodings and are refused here.
  wire undefinedOp = ~ctrl[`CTRL_FP_ENABLE] | // RULE15
                     (dpOp & ~ctrl[`CTRL_DP_IMPL]) | // RULE6
                     ~(ftoiActive | toFloat | isCompare); // RULE10
  wire ftoiUnsigned = isDirected ? ~instr.signednessRound : // RULE4
                      (instr.convOpcode != `OPC_TO_SIGNED); // RULE7

  round_t ftoiRound;
  unpacked_t srcA;
  unpacked_t srcB;
  int_result_t ftoi;
  float_result_t itof;
  cmp_result_t cmp;
  fp_exc_t execExc;
  logic [63:0] execResult;
  assign ftoiRound = isDirected ? directedRound(instr.roundSelect) :
                     instr.signednessRound ? RND_ZERO : statusRound(roundMode); // RULE8
  assign srcA = unpackFp({operand[1], operand[0]}, dpOp, flushZero);
  assign srcB = unpackFp(instr.withZero ? 64'h0 : {operand[3], operand[2]}, dpOp, flushZero);
  assign ftoi = floatToInt(srcA, ftoiUnsigned, ftoiRound);
  assign itof = intToFloat(operand[0], ~instr.signednessRound, statusRound(roundMode), dpOp); // RULE9
  assign cmp = compareFp(srcA, srcB, instr.raiseOnAnyNan);
  wire denIn = flushZero & (srcA.isDen | (isCompare & srcB.isDen));
  assign execExc = toFloat ? itof.exc :
                   isCompare ? {cmp.exc.invalid, denIn, 1'b0} : // RULE12
                   {ftoi.exc.invalid, denIn, ftoi.exc.inexact}; // RULE11
  assign execResult = toFloat ? itof.value : {32'h0, ftoi.value}; // RULE14
  wire inExec = state == ST_EXEC;
  wire execFire = inExec & ~undefinedOp;
  wire [4:0] next_destIdx = joinIndex(instr.destField, instr.destExtra,
                                      dpOp & (isCompare | toFloat)); // RULE13
  wire [4:0] next_srcIdx = joinIndex(instr.srcField, instr.srcExtra, dpOp & ~toFloat); // RULE13

  // Hardware sets win over a software write landing in the same cycle.
  fp_exc_t next_cumExc;
  logic [`IRQ_WIDTH-1:0] events;
  logic [`IRQ_WIDTH-1:0] next_irqStatus;
  assign next_cumExc = (statusWrite ? {pwdata[`STATUS_IOC], pwdata[`STATUS_IDC],
                        pwdata[`STATUS_IXC]} : cumExc) | (execFire ? execExc : 3'h0);
  assign events[`IRQ_DONE] = inExec;
  assign events[`IRQ_INVALID] = execFire & execExc.invalid;
  assign events[`IRQ_DENORMAL] = execFire & execExc.denormal;
  assign events[`IRQ_INEXACT] = execFire & execExc.inexact;
  assign events[`IRQ_UNDEF] = inExec & undefinedOp; // RULE15
  assign next_irqStatus = (irqStatus & ~((writeDone & hitIrqClear) ?
                          pwdata[`IRQ_WIDTH-1:0] : '0)) | events;

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // One wait state gives the registered memory port time to deliver read data.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= accessCycle;
      pslverr <= accessCycle & ~mapped;
      prdata <= accessCycle ? readMux : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
      flushZero <= 1'b0;
      roundMode <= `RMODE_NEAREST;
      irqEnable <= '0;
    end else if (writeDone) begin
      if (hitCtrl) ctrl <= pwdata[1:0];
      if (hitStatus) flushZero <= pwdata[`STATUS_FZ];
      if (hitStatus) roundMode <= pwdata[`STATUS_RMODE_LSB +: 2];
      if (hitIrqEnable) irqEnable <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nzcv <= 4'h0;
      cumExc <= '0;
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      if (execFire & isCompare) nzcv <= cmp.nzcv;
      else if (statusWrite) nzcv <= pwdata[`STATUS_NZCV_LSB +: 4];
      cumExc <= next_cumExc;
      irqStatus <= next_irqStatus;
      irq <= |(irqStatus & irqEnable);
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // An instruction written while busy is dropped; software checks the busy bit.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      loadStep <= 3'h0;
      instr <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          loadStep <= 3'h0;
          if (writeDone & hitInstr) begin
            instr <= instr_t'(pwdata[$bits(instr_t)-1:0]);
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          loadStep <= loadStep + 3'h1;
          if (loadStep == `LOAD_LAST) state <= ST_EXEC;
        end
        ST_EXEC: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      operand <= '0;
    end else if (state == ST_LOAD && loadStep != 3'h0) begin
      operand[2'(loadStep - 3'h1)] <= memExecData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result <= 64'h0;
      destIdx <= 5'h0;
      srcIdx <= 5'h0;
    end else if (execFire) begin
      if (!isCompare) result <= execResult; // RULE14
      destIdx <= next_destIdx;
      srcIdx <= next_srcIdx;
    end
  end

endmodule

/* fp_cvt_map.svh */
// Register map, field positions, encodings and counts of the convert/compare unit.
// Assumes byte addresses on an 8-bit APB address and 32-bit data words.
`ifndef FP_CVT_MAP_SVH
`define FP_CVT_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_INSTR 8'h08
`define ADDR_INDEX 8'h0c
`define ADDR_OPERAND_PAGE 4'h1
`define ADDR_RESULT_LO 8'h20
`define ADDR_RESULT_HI 8'h24
`define ADDR_IRQ_STATUS 8'h28
`define ADDR_IRQ_CLEAR 8'h2c
`define ADDR_IRQ_ENABLE 8'h30

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_FP_ENABLE 0
`define CTRL_DP_IMPL 1
`define CTRL_RESET 2'h2
`define STATUS_NZCV_LSB 28
`define STATUS_FZ 24
`define STATUS_RMODE_LSB 22
`define STATUS_IDC 7
`define STATUS_IXC 4
`define STATUS_IOC 0
`define INDEX_SRC_LSB 8
`define INDEX_BUSY 16
`define IRQ_DONE 0
`define IRQ_INVALID 1
`define IRQ_DENORMAL 2
`define IRQ_INEXACT 3
`define IRQ_UNDEF 4
`define IRQ_WIDTH 5

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define RMODE_NEAREST 2'h0
`define RMODE_PLUS 2'h1
`define RMODE_MINUS 2'h2
`define RSEL_AWAY 2'h0
`define RSEL_EVEN 2'h1
`define RSEL_PLUS 2'h2
`define OPC_TO_FLOAT 3'h0
`define OPC_TO_INT_HI 2'h2
`define OPC_TO_SIGNED 3'h5
`define NZCV_UNORDERED 4'h3
`define NZCV_LESS 4'h8
`define NZCV_EQUAL 4'h6
`define NZCV_GREATER 4'h2

// ----------------------------------------------------------------------
// Arithmetic constants and sequencing counts
// ----------------------------------------------------------------------
`define SP_BIAS 13'h007f
`define DP_BIAS 13'h03ff
`define SP_EXP_ONES 11'h0ff
`define DP_EXP_ONES 11'h7ff
`define FTOI_POINT 13'h0034
`define FTOI_MAX_EXP 13'h0020
`define FTOI_MIN_EXP 13'h1fc0
`define FTOI_HUGE 65'h1_0000_0000_0000_0000
`define SAT_UNSIGNED 32'hffff_ffff
`define SAT_POS 32'h7fff_ffff
`define SAT_NEG 32'h8000_0000
`define LOAD_LAST 3'h4

`endif

/* fp_cvt_pkg.sv */
// Types used by the convert/compare unit and imported by its testbench.
// Assumes nothing beyond the map header for numeric values.
package fp_cvt_pkg;

  typedef enum logic [2:0] {
    RND_NEAR_EVEN = 3'b000,
    RND_PLUS = 3'b001,
    RND_MINUS = 3'b010,
    RND_ZERO = 3'b011,
    RND_NEAR_AWAY = 3'b100
  } round_t;

  typedef enum logic [1:0] {
    OP_DIRECTED = 2'b00,
    OP_INTCVT = 2'b01,
    OP_COMPARE = 2'b10,
    OP_RESERVED = 2'b11
  } op_class_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  typedef struct packed {
    op_class_t opClass;
    logic [1:0] roundSelect;
    logic [2:0] convOpcode;
    logic precisionSelect;
    logic signednessRound;
    logic raiseOnAnyNan;
    logic withZero;
    logic inCondBlock;
    logic [3:0] destField;
    logic destExtra;
    logic [3:0] srcField;
    logic srcExtra;
  } instr_t;

  typedef struct packed {
    logic sign;
    logic [12:0] exp;
    logic [52:0] mant;
    logic isNan;
    logic isSnan;
    logic isInf;
    logic isZero;
    logic isDen;
  } unpacked_t;

  typedef struct packed {
    logic invalid;
    logic denormal;
    logic inexact;
  } fp_exc_t;

  typedef struct packed {
    logic [31:0] value;
    fp_exc_t exc;
  } int_result_t;

  typedef struct packed {
    logic [63:0] value;
    fp_exc_t exc;
  } float_result_t;

  typedef struct packed {
    logic [3:0] nzcv;
    fp_exc_t exc;
  } cmp_result_t;

endpackage

/* operand_store.sv */
// Four-word operand memory with a bus read port and an execution read port.
// Assumes one writer; both read ports return data one clock after the address.
`timescale 1ns/1ns
module operand_store (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [1:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [1:0] busAddr,
  output logic [31:0] busData,
  input wire logic [1:0] execAddr,
  output logic [31:0] execData
);

  logic [31:0] words [4];

  // Contents are not reset; software loads operands before issuing.
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      words[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busData <= 32'h0;
      execData <= 32'h0;
    end else begin
      busData <= words[busAddr];
      execData <= words[execAddr];
    end
  end

endmodule

/* fp_cvt_properties.sv */
// Bus and interrupt timing checks for the convert/compare unit.
// Assumes it is bound to the unit's top module.
`timescale 1ns/1ns
module fp_cvt_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  wire wrDone = psel && penable && pready && pwrite;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on a refused transfer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_irq_rise: assert property ($rose(irq) |-> $past(wrDone, 8) || $past(wrDone, 7) ||
    $past(wrDone, 2) || $past(wrDone)) else $error("irq rose without a cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(wrDone, 2) || $past(wrDone))
    else $error("irq fell without a write");
endmodule
bind fp_int_convert_compare_unit fp_cvt_properties u_fp_cvt_properties (.core_clk(core_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

/* core_issue_model.sv */
// APB master standing for the core that issues work to the unit.
// Assumes the unit answers every transfer with pready.
`timescale 1ns/1ns
module core_issue_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    // Released lines flip so a stale value cannot pass for a held one.
    {psel, penable, paddr, pwdata} <= {2'b00, ~paddr, ~pwdata};
  endtask
endmodule

/* tb_fp_int_convert_compare_unit.sv */
// Self-checking bench for the convert/compare unit.
// Assumes the core model drives the bus; results polled after irq.
`timescale 1ns/1ns
`include "fp_cvt_map.svh"
module tb_fp_int_convert_compare_unit import fp_cvt_pkg::*;;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  fp_int_convert_compare_unit u_fp_int_convert_compare_unit (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  core_issue_model u_core_issue_model (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task test_done;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_core_issue_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    u_core_issue_model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // Flag bits f are precision, signedness and raise-on-NaN; the conditional bit stays 0.
  function automatic logic [31:0] mk(logic [1:0] c, logic [1:0] r, logic [2:0] o,
    logic [2:0] f);
    return {10'h0, c, r, o, f, 12'h0};
  endfunction
  // Undefined work leaves the result alone, so only the flags are judged then.
  task op(input logic [31:0] ins, input logic [31:0] res, input logic [4:0] st);
    wr(`ADDR_IRQ_CLEAR, 32'h1f);
    wr(`ADDR_INSTR, ins);
    while (irq !== 1'b1) @(posedge core_clk);
    rd(`ADDR_IRQ_STATUS);
    chk(q, {27'h0, st});
    rd(`ADDR_RESULT_LO);
    if (!st[4]) chk(q, res);
  endtask
  task t_disabled;
    rd(`ADDR_CTRL);
    chk(q, 32'h2);
    op(mk(2'h1, 2'h0, 3'h5, 3'h2), 0, 5'h11);
    $display("disabled done");
  endtask
  task t_directed;
    int x[4] = '{3, 2, 3, 2};
    for (int i = 0; i < 4; i++) op(mk(2'h0, 2'(i), 3'h0, 3'h2), x[i], 5'h09);
    wr(8'h10, 32'hc0200000);
    op(mk(2'h0, 2'h3, 3'h0, 3'h0), 0, 5'h03);
    $display("directed done");
  endtask
  task t_intcvt;
    wr(8'h10, 32'h40300000);
    op(mk(2'h1, 2'h0, 3'h5, 3'h2), 2, 5'h09);
    op(mk(2'h1, 2'h0, 3'h5, 3'h0), 3, 5'h09);
    op(mk(2'h1, 2'h0, 3'h4, 3'h2), 2, 5'h09);
    op(mk(2'h1, 2'h0, 3'h1, 3'h2), 0, 5'h11);
    wr(`ADDR_STATUS, 32'h01000000);
    wr(8'h10, 32'h1);
    op(mk(2'h1, 2'h0, 3'h5, 3'h2), 0, 5'h05);
    wr(`ADDR_STATUS, 32'h0);
    $display("intcvt done");
  endtask
  task t_tofloat;
    wr(8'h10, 32'hffffffff);
    op(mk(2'h1, 2'h0, 3'h0, 3'h2), 32'hbf800000, 5'h01);
    op(mk(2'h1, 2'h0, 3'h0, 3'h0), 32'h4f800000, 5'h09);
    $display("tofloat done");
  endtask
  task t_compare;
    wr(8'h10, 32'h7fc00000);
    wr(8'h18, 32'h3f800000);
    op(mk(2'h2, 2'h0, 3'h0, 3'h1), 32'h4f800000, 5'h03);
    rd(`ADDR_STATUS);
    chk({28'h0, q[31:28]}, 32'h3);
    op(mk(2'h2, 2'h0, 3'h0, 3'h0), 32'h4f800000, 5'h01);
    $display("compare done");
  endtask
  task t_double;
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h40040000);
    op(mk(2'h1, 2'h0, 3'h5, 3'h6) | 32'heb, 2, 5'h09);
    rd(`ADDR_INDEX);
    chk(q, 32'h1507);
    wr(`ADDR_CTRL, 32'h1);
    op(mk(2'h1, 2'h0, 3'h5, 3'h6), 0, 5'h11);
    $display("double done");
  endtask
  task t_unmapped;
    rd(8'hfc);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("unmapped done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'h0);
    wr(8'h10, 32'h40200000);
    wr(`ADDR_IRQ_ENABLE, 32'h1f);
    t_disabled;
    wr(`ADDR_CTRL, 32'h3);
    t_directed;
    t_intcvt;
    t_tofloat;
    t_compare;
    t_double;
    t_unmapped;
    test_done;
  end
endmodule
